// ---- motor_ctrl_pkg.sv ----
/*
 * Constants for the motor driver control register bank: offsets, field positions,
 * reset values, masks, lock codes, serial frame layout and timing counts.
 * Assumes a 100 MHz system clock and 16-bit serial frames.
 */
package motor_ctrl_pkg;

   // Register offsets.
   localparam logic [5:0] ADDR_LOCK        = 6'h03;
   localparam logic [5:0] ADDR_DRIVE       = 6'h04;
   localparam logic [5:0] ADDR_SUPPLY      = 6'h05;
   localparam logic [5:0] ADDR_OVERCURRENT = 6'h06;
   localparam logic [5:0] ADDR_LIMIT       = 6'h07;
   localparam logic [5:0] ADDR_RSVD_A      = 6'h08;
   localparam logic [5:0] ADDR_HALL        = 6'h09;
   localparam logic [5:0] ADDR_SPEED       = 6'h0A;
   localparam logic [5:0] ADDR_ADVANCE     = 6'h0B;
   localparam logic [5:0] ADDR_RSVD_B      = 6'h0C;
   localparam int         ADDR_FIRST       = 3;
   localparam int         ADDR_LAST        = 12;

   // Reset values.
   localparam logic [7:0] RST_LOCK = 8'h03;
   localparam logic [7:0] RST_DRIVE = 8'h20;
   localparam logic [7:0] RST_SUPPLY = 8'h46;
   localparam logic [7:0] RST_OVERCURRENT = 8'h10;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_SPEED = 8'h41;

   // Writable and readable bits; everything else is reserved.
   localparam logic [7:0] MASK_LOCK = 8'h07;
   localparam logic [7:0] MASK_DRIVE = 8'h26;
   localparam logic [7:0] MASK_SUPPLY = 8'h1F;
   localparam logic [7:0] MASK_OVERCURRENT = 8'hFB;
   localparam logic [7:0] MASK_LIMIT = 8'h44;
   localparam logic [7:0] MASK_HALL = 8'h1D;
   localparam logic [7:0] MASK_SPEED = 8'hDF;
   localparam logic [7:0] MASK_ADVANCE = 8'h07;

   // Field positions.
   localparam int LOCK_LSB = 0;
   localparam int DRIVE_MODE_BIT = 5;
   localparam int RECT_LSB = 1;
   localparam int CLEAR_BIT = 0;
   localparam int FULL_DUTY_BIT = 4;
   localparam int OV_LEVEL_BIT = 3;
   localparam int OV_ENABLE_BIT = 2;
   localparam int SERIAL_REPORT_BIT = 1;
   localparam int THERMAL_REPORT_BIT = 0;
   localparam int STANDBY_BIT = 7;
   localparam int CYCLE_CLEAR_BIT = 6;
   localparam int FILTER_LSB = 4;
   localparam int RETRY_BIT = 3;
   localparam int POLICY_LSB = 0;
   localparam int RECIR_BIT = 6;
   localparam int AUTO_SYNC_BIT = 2;
   localparam int HYST_BIT = 4;
   localparam int BRAKE_BIT = 3;
   localparam int COAST_BIT = 2;
   localparam int DIRECTION_BIT = 0;
   localparam int SPEED_DIV_LSB = 6;
   localparam int STALL_RETRY_BIT = 4;
   localparam int STALL_DET_LSB = 2;
   localparam int STALL_POLICY_LSB = 0;
   localparam int LEAD_LSB = 0;

   // Lock codes.
   localparam logic [2:0] LOCK_CODE_OPEN = 3'h3;
   localparam logic [2:0] LOCK_CODE_SHUT = 3'h6;

   // Serial frame layout.
   localparam logic [4:0] FRAME_BITS = 5'h10;
   localparam logic [4:0] STATUS_BITS = 5'h08;
   localparam int RW_BIT = 15;
   localparam int ADDR_MSB = 14;
   localparam int ADDR_LSB = 9;

   // Timing: overcurrent filter times, rounded up to whole system clock cycles.
   localparam int SYS_CLK_PERIOD_NS = 10;
   localparam int FILTER_T0_NS = 200;
   localparam int FILTER_T1_NS = 600;
   localparam int FILTER_T2_NS = 1250;
   localparam int FILTER_T3_NS = 1600;
   localparam logic [7:0] FILTER_C0 = 8'((FILTER_T0_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);
   localparam logic [7:0] FILTER_C1 = 8'((FILTER_T1_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);
   localparam logic [7:0] FILTER_C2 = 8'((FILTER_T2_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);
   localparam logic [7:0] FILTER_C3 = 8'((FILTER_T3_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);

   // Commutation lead in electrical degrees, per code.
   localparam logic [4:0] LEAD_DEG [8] = '{5'h00, 5'h04, 5'h07, 5'h0B, 5'h0F, 5'h14, 5'h19, 5'h1E};

   function automatic logic [7:0] reset_value(input logic [5:0] addr);
      if (addr == ADDR_LOCK) reset_value = RST_LOCK;
      else if (addr == ADDR_DRIVE) reset_value = RST_DRIVE;
      else if (addr == ADDR_SUPPLY) reset_value = RST_SUPPLY;
      else if (addr == ADDR_OVERCURRENT) reset_value = RST_OVERCURRENT;
      else if (addr == ADDR_SPEED) reset_value = RST_SPEED;
      else reset_value = RST_ZERO;
   endfunction : reset_value

   function automatic logic [7:0] field_mask(input logic [5:0] addr);
      if (addr == ADDR_LOCK) field_mask = MASK_LOCK;
      else if (addr == ADDR_DRIVE) field_mask = MASK_DRIVE;
      else if (addr == ADDR_SUPPLY) field_mask = MASK_SUPPLY;
      else if (addr == ADDR_OVERCURRENT) field_mask = MASK_OVERCURRENT;
      else if (addr == ADDR_LIMIT) field_mask = MASK_LIMIT;
      else if (addr == ADDR_HALL) field_mask = MASK_HALL;
      else if (addr == ADDR_SPEED) field_mask = MASK_SPEED;
      else if (addr == ADDR_ADVANCE) field_mask = MASK_ADVANCE;
      else field_mask = RST_ZERO;
   endfunction : field_mask

endpackage : motor_ctrl_pkg

// ---- motor_driver_control_regs.sv ----
/*
 * Control register bank of a sensored trapezoidal motor driver, reached over a
 * 16-bit serial frame. Capture runs on the serial clock; settings live on sys_clk.
 * Assumes the host keeps the select high for at least 40 ns between frames and
 * idles the serial clock low.
 */
// Function
// - Writing 011b to lock field unlocks all
// - After 110b, only lock field accepts writes
// - Serial output pin: 0 open-drain, 1 push-pull
// - Two-bit rectification and position input mode
// - Clear-fault bit pulses once, self clears
// - Full-duty switching rate select, 20 or 40 kHz
// - Overvoltage enable and threshold level bits
// - Fault pin reporting of serial and thermal
// - Standby bit enters low-power standby mode
// - Overcurrent cleared on next speed cycle
// - Overcurrent filter time from two-bit code
// - Overcurrent policy and retry wait select
// - Current-limit recirculation: brake or coast path
// - Automatic synchronous rectification enable bit
// - Position comparator hysteresis, 5 or 50 mV
// - Brake behaviour bit and coast mode bit
// - Direction bit sets commutation rotation sense
// - Speed feedback output divider select
// - Stall policy field, reset code one
// - Stall detect time and stall retry wait
// - Commutation lead angle from three-bit code
// - Defaults restored at reset and sleep entry
`timescale 1ns/1ps

module motor_driver_control_regs
   import motor_ctrl_pkg::*;
(
   // Clock, reset and power state.
   input  wire logic       sys_clk,
   input  wire logic       reset_n,
   input  wire logic       clk_en,
   input  wire logic       sleep_entry,
   // Serial link.
   input  wire logic       sclk,
   input  wire logic       scs_n,
   input  wire logic       sdi,
   output logic            sdo_out,
   output logic            sdo_oe_n,
   // Status byte returned at the head of every frame.
   input  wire logic [7:0] device_status,
   // Settings to the commutation and protection logic.
   output logic            serial_out_drive_mode,
   output logic [1:0]      rectification_mode,
   output logic            clear_latched_faults,
   output logic            full_duty_fast,
   output logic            overvoltage_level,
   output logic            overvoltage_enable,
   output logic            serial_fault_report_disable,
   output logic            thermal_warning_report,
   output logic            driver_standby,
   output logic            overcurrent_cycle_clear,
   output logic [1:0]      overcurrent_filter_time,
   output logic [7:0]      overcurrent_filter_cycles,
   output logic            overcurrent_retry_wait,
   output logic [1:0]      overcurrent_policy,
   output logic            limit_recirculation_path,
   output logic            auto_sync_rect_enable,
   output logic            position_comparator_hysteresis,
   output logic            brake_coasts,
   output logic            coast_enable,
   output logic            motor_direction,
   output logic [1:0]      speed_feedback_divider,
   output logic            stall_retry_wait,
   output logic [1:0]      stall_detect_time,
   output logic [1:0]      stall_policy,
   output logic [2:0]      commutation_lead_angle,
   output logic [4:0]      lead_angle_degrees,
   output logic            register_lock_engaged
);

   logic [7:0]  ctl_reg [ADDR_FIRST:ADDR_LAST];
   logic        locked_reg;
   logic        clear_pulse_reg;
   logic [7:0]  filter_cycles_reg;
   logic [4:0]  lead_deg_reg;
   logic [7:0]  status_snapshot_reg;
   logic        cs_meta_reg;
   logic        cs_sync_reg;
   logic        cs_prev_reg;
   logic [4:0]  in_count_reg;
   logic [14:0] shift_in_reg;
   logic [5:0]  read_addr_reg;
   logic [15:0] held_word_reg;
   logic        held_ok_reg;
   logic        held_tog_reg;
   logic        seen_tog_reg;
   logic [4:0]  out_count_reg;
   logic        sdo_out_reg;
   logic        sdo_oe_n_reg;
   logic        frame_end;
   logic        write_req;
   logic [5:0]  frame_addr;
   logic [7:0]  frame_data;
   logic [7:0]  read_byte;
   logic        out_bit;
   logic [79:0] ctl_flat;

   function automatic logic addr_in_bank(input logic [5:0] addr);
      addr_in_bank = (addr >= ADDR_LOCK) && (addr <= ADDR_RSVD_B);
   endfunction : addr_in_bank

   // Reserved bits are masked on the way out, whatever they hold.
   function automatic logic [7:0] read_value(input logic [5:0] addr);
      if (addr_in_bank(addr)) read_value = ctl_reg[addr] & field_mask(addr);
      else read_value = 8'h00;
   endfunction : read_value

   function automatic logic [7:0] filter_cycles(input logic [1:0] code);
      case (code)
         2'h0: filter_cycles = FILTER_C0;
         2'h1: filter_cycles = FILTER_C1;
         2'h2: filter_cycles = FILTER_C2;
         default: filter_cycles = FILTER_C3;
      endcase
   endfunction : filter_cycles

   // ---------------- Serial clock domain ----------------
   // Bits are captured on the falling edge; the select resets the frame counter.
   always_ff @(negedge sclk or posedge scs_n or negedge reset_n) begin
      if (scs_n || !reset_n) begin
         in_count_reg  <= 5'h00;
         shift_in_reg  <= 15'h0000;
         read_addr_reg <= 6'h00;
      end else begin
         shift_in_reg <= {shift_in_reg[13:0], sdi};
         if (in_count_reg <= FRAME_BITS) begin
            in_count_reg <= in_count_reg + 5'h01;
         end
         if (in_count_reg == 5'h06) begin
            read_addr_reg <= {shift_in_reg[4:0], sdi};
         end
      end
   end

   // The word is only marked good when the last bit seen was the sixteenth.
   always_ff @(negedge sclk or negedge reset_n) begin
      if (!reset_n) begin
         held_word_reg <= 16'h0000;
         held_ok_reg   <= 1'b0;
         held_tog_reg  <= 1'b0;
      end else if (in_count_reg == FRAME_BITS - 5'h01) begin
         held_word_reg <= {shift_in_reg, sdi};
         held_ok_reg   <= 1'b1;
         held_tog_reg  <= ~held_tog_reg;
      end else begin
         held_ok_reg <= 1'b0;
      end
   end

   // Register contents cross as quasi-static data: writes only land between frames.
   assign read_byte = read_value(read_addr_reg);
   assign out_bit   = (out_count_reg < STATUS_BITS) ? status_snapshot_reg[~out_count_reg[2:0]] :
                      (out_count_reg < FRAME_BITS)  ? read_byte[~out_count_reg[2:0]] : 1'b0;

   // Data is launched on the rising edge; open-drain mode only ever pulls low.
   always_ff @(posedge sclk or posedge scs_n or negedge reset_n) begin
      if (scs_n || !reset_n) begin
         out_count_reg <= 5'h00;
         sdo_out_reg   <= 1'b1;
         sdo_oe_n_reg  <= 1'b1;
      end else begin
         if (out_count_reg < FRAME_BITS) begin
            out_count_reg <= out_count_reg + 5'h01;
         end
         if (ctl_reg[ADDR_DRIVE][DRIVE_MODE_BIT]) begin
            sdo_out_reg  <= out_bit;
            sdo_oe_n_reg <= 1'b0;
         end else begin
            sdo_out_reg  <= 1'b0;
            sdo_oe_n_reg <= out_bit;
         end
      end
   end

   assign sdo_out  = sdo_out_reg;
   assign sdo_oe_n = sdo_oe_n_reg;

   // ---------------- System clock domain ----------------
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cs_meta_reg <= 1'b1;
         cs_sync_reg <= 1'b1;
         cs_prev_reg <= 1'b1;
      end else if (clk_en) begin
         cs_meta_reg <= scs_n;
         cs_sync_reg <= cs_meta_reg;
         cs_prev_reg <= cs_sync_reg;
      end
   end

   // The status byte is frozen while a frame is in progress.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         status_snapshot_reg <= 8'h00;
      end else if (clk_en && cs_sync_reg) begin
         status_snapshot_reg <= device_status;
      end
   end

   // The held word is stable once the select has been high for two cycles.
   assign frame_end  = cs_sync_reg && !cs_prev_reg;
   assign frame_addr = held_word_reg[ADDR_MSB:ADDR_LSB];
   assign frame_data = held_word_reg[7:0];
   assign write_req  = frame_end && held_ok_reg && !held_word_reg[RW_BIT] && !(^held_word_reg)
                       && (held_tog_reg != seen_tog_reg) && addr_in_bank(frame_addr);

   // A frame without any serial clock leaves the toggle alone, so the old word is not applied again.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         seen_tog_reg <= 1'b0;
      end else if (clk_en && frame_end) begin
         seen_tog_reg <= held_tog_reg;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = ADDR_FIRST; i <= ADDR_LAST; i++) begin
            ctl_reg[i] <= reset_value(6'(i));
         end
      end else if (clk_en) begin
         if (sleep_entry) begin
            for (int i = ADDR_FIRST; i <= ADDR_LAST; i++) begin
               ctl_reg[i] <= reset_value(6'(i));
            end
         end else if (write_req) begin
            if (frame_addr == ADDR_LOCK) begin
               if (frame_data[2:0] == LOCK_CODE_OPEN || frame_data[2:0] == LOCK_CODE_SHUT) begin
                  ctl_reg[ADDR_LOCK] <= {5'h00, frame_data[2:0]};
               end
            end else if (!locked_reg) begin
               ctl_reg[frame_addr] <= (frame_data & field_mask(frame_addr))
                                      | (ctl_reg[frame_addr] & ~field_mask(frame_addr));
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         locked_reg <= 1'b0;
      end else if (clk_en) begin
         if (sleep_entry) begin
            locked_reg <= 1'b0;
         end else if (write_req && frame_addr == ADDR_LOCK) begin
            if (frame_data[2:0] == LOCK_CODE_SHUT) begin
               locked_reg <= 1'b1;
            end else if (frame_data[2:0] == LOCK_CODE_OPEN) begin
               locked_reg <= 1'b0;
            end
         end
      end
   end

   // The clear-fault bit is never stored; it becomes a one-cycle pulse.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         clear_pulse_reg <= 1'b0;
      end else if (clk_en) begin
         clear_pulse_reg <= write_req && !sleep_entry && !locked_reg && frame_addr == ADDR_DRIVE
                            && frame_data[CLEAR_BIT];
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         filter_cycles_reg <= FILTER_C1;
         lead_deg_reg      <= LEAD_DEG[0];
      end else if (clk_en) begin
         filter_cycles_reg <= filter_cycles(ctl_reg[ADDR_OVERCURRENT][FILTER_LSB +: 2]);
         lead_deg_reg      <= LEAD_DEG[ctl_reg[ADDR_ADVANCE][LEAD_LSB +: 3]];
      end
   end

   // Settings are bits of bank flip-flops, except the clear pulse, filter cycles, lead degrees and lock flag.
   assign serial_out_drive_mode          = ctl_reg[ADDR_DRIVE][DRIVE_MODE_BIT];
   assign rectification_mode             = ctl_reg[ADDR_DRIVE][RECT_LSB +: 2];
   assign clear_latched_faults           = clear_pulse_reg;
   assign full_duty_fast                 = ctl_reg[ADDR_SUPPLY][FULL_DUTY_BIT];
   assign overvoltage_level              = ctl_reg[ADDR_SUPPLY][OV_LEVEL_BIT];
   assign overvoltage_enable             = ctl_reg[ADDR_SUPPLY][OV_ENABLE_BIT];
   assign serial_fault_report_disable    = ctl_reg[ADDR_SUPPLY][SERIAL_REPORT_BIT];
   assign thermal_warning_report         = ctl_reg[ADDR_SUPPLY][THERMAL_REPORT_BIT];
   assign driver_standby                 = ctl_reg[ADDR_OVERCURRENT][STANDBY_BIT];
   assign overcurrent_cycle_clear        = ctl_reg[ADDR_OVERCURRENT][CYCLE_CLEAR_BIT];
   assign overcurrent_filter_time        = ctl_reg[ADDR_OVERCURRENT][FILTER_LSB +: 2];
   assign overcurrent_filter_cycles      = filter_cycles_reg;
   assign overcurrent_retry_wait         = ctl_reg[ADDR_OVERCURRENT][RETRY_BIT];
   assign overcurrent_policy             = ctl_reg[ADDR_OVERCURRENT][POLICY_LSB +: 2];
   assign limit_recirculation_path       = ctl_reg[ADDR_LIMIT][RECIR_BIT];
   assign auto_sync_rect_enable          = ctl_reg[ADDR_LIMIT][AUTO_SYNC_BIT];
   assign position_comparator_hysteresis = ctl_reg[ADDR_HALL][HYST_BIT];
   assign brake_coasts                   = ctl_reg[ADDR_HALL][BRAKE_BIT];
   assign coast_enable                   = ctl_reg[ADDR_HALL][COAST_BIT];
   assign motor_direction                = ctl_reg[ADDR_HALL][DIRECTION_BIT];
   assign speed_feedback_divider         = ctl_reg[ADDR_SPEED][SPEED_DIV_LSB +: 2];
   assign stall_retry_wait               = ctl_reg[ADDR_SPEED][STALL_RETRY_BIT];
   assign stall_detect_time              = ctl_reg[ADDR_SPEED][STALL_DET_LSB +: 2];
   assign stall_policy                   = ctl_reg[ADDR_SPEED][STALL_POLICY_LSB +: 2];
   assign commutation_lead_angle         = ctl_reg[ADDR_ADVANCE][LEAD_LSB +: 3];
   assign lead_angle_degrees             = lead_deg_reg;
   assign register_lock_engaged          = locked_reg;

   // ---------------- Checks ----------------
   always_comb begin
      for (int i = ADDR_FIRST; i <= ADDR_LAST; i++) begin
         ctl_flat[(i - ADDR_FIRST) * 8 +: 8] = ctl_reg[i];
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   sequence s_write(logic [5:0] addr);
      clk_en && !sleep_entry && write_req && frame_addr == addr;
   endsequence

   sequence s_lock_code(logic [2:0] code);
      s_write(ADDR_LOCK) ##0 (frame_data[2:0] == code);
   endsequence

   a_locked_ignores_write: assert property (
      (clk_en && !sleep_entry && locked_reg && write_req && frame_addr != ADDR_LOCK) |=> $stable(ctl_flat))
      else $error("write landed while the bank was locked");

   a_unlock_code_opens: assert property (
      s_lock_code(LOCK_CODE_OPEN) |=> !register_lock_engaged && read_value(ADDR_LOCK) == 8'h03)
      else $error("unlock code did not open the bank");

   a_lock_code_shuts: assert property (
      s_lock_code(LOCK_CODE_SHUT) |=> register_lock_engaged && read_value(ADDR_LOCK) == 8'h06)
      else $error("lock code did not lock the bank");

   a_other_code_keeps: assert property (
      (s_write(ADDR_LOCK) ##0 (frame_data[2:0] != LOCK_CODE_OPEN && frame_data[2:0] != LOCK_CODE_SHUT))
      |=> $stable(locked_reg) && $stable(ctl_flat))
      else $error("other lock code changed the lock state");

   a_clear_single_pulse: assert property (
      $rose(clear_latched_faults) |-> $past(write_req && frame_addr == ADDR_DRIVE && frame_data[CLEAR_BIT])
      ##1 (!$past(clk_en) || !clear_latched_faults || $past(write_req)))
      else $error("clear pulse without cause or too long");

   a_sleep_defaults: assert property (
      (clk_en && sleep_entry) |=> serial_out_drive_mode && overcurrent_filter_time == 2'h1
      && stall_policy == 2'h1 && speed_feedback_divider == 2'h1 && overvoltage_enable && !register_lock_engaged)
      else $error("defaults not restored on sleep entry");

   a_write_lands_next: assert property (
      (s_write(ADDR_HALL) ##0 !locked_reg) |=> motor_direction == $past(frame_data[DIRECTION_BIT])
      && coast_enable == $past(frame_data[COAST_BIT]))
      else $error("write did not take effect on the next cycle");

   a_filter_decode: assert property (
      (clk_en && overcurrent_filter_time == 2'h2) |=> overcurrent_filter_cycles == FILTER_C2 || !$past(clk_en))
      else $error("filter cycles do not follow the filter code");

   a_bad_frame_dropped: assert property (
      (clk_en && !sleep_entry && frame_end && (!held_ok_reg || ^held_word_reg || held_tog_reg == seen_tog_reg))
      |=> $stable(ctl_flat))
      else $error("short, long or bad parity frame changed the bank");

   a_reserved_read_zero: assert property (
      (s_write(ADDR_LIMIT) ##0 !locked_reg) |=> read_value(ADDR_LIMIT) == ($past(frame_data) & MASK_LIMIT))
      else $error("reserved bits did not read as zero");

endmodule : motor_driver_control_regs

// ---- spi_host_model.sv ----
/* Serial host model that clocks out n bits of a 16-bit word per frame, MSB first.
   Assumes a pull-up on the data-out wire and sclk idle low. */
`timescale 1ns/1ps
module spi_host_model (
   // Link outputs.
   output logic      sclk,
   output logic      scs_n,
   output logic      sdi,
   // Link inputs.
   input  wire logic sdo_out,
   input  wire logic sdo_oe_n
);
   wire sdo_wire = sdo_oe_n ? 1'b1 : sdo_out;
   initial begin
      sclk = 1'b0;
      scs_n = 1'b1;
      sdi = 1'b0;
   end
   task automatic frame(input logic [15:0] w, input int n, output logic [15:0] r);
      r = 16'h0000;
      scs_n = 1'b0;
      #83;
      for (int i = 0; i < n; i++) begin
         sclk = 1'b1;
         sdi = w[15-i];
         #80;
         sclk = 1'b0;
         r = {r[14:0], sdo_wire};
         #80;
      end
      scs_n = 1'b1;
      sdi = ~sdi;
      #200;
   endtask : frame
endmodule : spi_host_model

// ---- motor_driver_control_regs_tb.sv ----
/* Self-checking bench for the control register bank.
   Assumes the serial host model and a 100 MHz system clock. */
`timescale 1ns/1ps
module motor_driver_control_regs_tb;
   import motor_ctrl_pkg::*;
   logic sys_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, sleep_entry = 1'b0;
   logic sclk, scs_n, sdi, sdo_out, sdo_oe_n, serial_out_drive_mode, clear_latched_faults;
   logic [7:0] device_status = 8'h00, overcurrent_filter_cycles;
   logic full_duty_fast, overvoltage_level, overvoltage_enable, serial_fault_report_disable;
   logic thermal_warning_report, driver_standby, overcurrent_cycle_clear, overcurrent_retry_wait;
   logic limit_recirculation_path, auto_sync_rect_enable, position_comparator_hysteresis;
   logic brake_coasts, coast_enable, motor_direction, stall_retry_wait, register_lock_engaged;
   logic [1:0] rectification_mode, overcurrent_filter_time, overcurrent_policy;
   logic [1:0] speed_feedback_divider, stall_detect_time, stall_policy;
   logic [2:0] commutation_lead_angle;
   logic [4:0] lead_angle_degrees;
   logic [15:0] exp_q[$], seen, e;
   string what;
   int n_fail = 0, tests_run = 0, cycles = 0, pulses = 0, seed = 15;
   event got;
   localparam logic [7:0] MASKS [10] = '{MASK_LOCK, MASK_DRIVE, MASK_SUPPLY, MASK_OVERCURRENT,
      MASK_LIMIT, 8'h00, MASK_HALL, MASK_SPEED, MASK_ADVANCE, 8'h00};
   localparam logic [7:0] RSTS [10] = '{8'h03, 8'h20, 8'h06, 8'h10, 8'h00, 8'h00, 8'h00, 8'h41, 8'h00, 8'h00};
   motor_driver_control_regs motor_driver_control_regs_inst (.*);
   spi_host_model spi_host_model_inst (.*);
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      pulses <= pulses + (clear_latched_faults === 1'b1);
      if (cycles == 60000) begin
         n_fail++;
         test_done();
      end
   end
   always @(got) begin
      tests_run++;
      e = exp_q.pop_front();
      if (e !== seen) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, e, seen);
      end
   end
   task automatic test_done;
      $display("checks %0d failures %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : test_done
   task automatic check(input string w, input logic [15:0] x, input logic [15:0] s);
      exp_q.push_back(x);
      what = w;
      seen = s;
      -> got;
      #1;
   endtask : check
   task automatic xfer(input logic rw, input logic [5:0] a, input logic [7:0] d, input int n,
                       input logic bad, output logic [15:0] r);
      logic [15:0] w;
      w = {rw, a, 1'b0, d};
      w[8] = (^w) ^ bad;
      @(negedge sys_clk);
      spi_host_model_inst.frame(w, n, r);
   endtask : xfer
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [15:0] r;
      xfer(1'b0, a, d, 16, 1'b0, r);
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic [7:0] x);
      logic [15:0] r;
      xfer(1'b1, a, 8'h00, 16, 1'b0, r);
      check("read", {device_status, x}, r);
   endtask : rd
   initial begin
      logic [7:0] d;
      logic [15:0] r;
      int p;
      repeat (20) @(negedge sys_clk);
      reset_n = 1'b1;
      repeat (5) @(negedge sys_clk);
      device_status = 8'($random(seed));
      for (int i = 0; i < 10; i++) rd(6'(i + 3), RSTS[i]);
      rd(6'h0D, 8'h00);
      check("filter", 16'(FILTER_C1), 16'(overcurrent_filter_cycles));
      for (int i = 1; i < 10; i++) begin
         d = 8'($random(seed));
         wr(6'(i + 3), d);
         rd(6'(i + 3), d & MASKS[i]);
      end
      wr(ADDR_ADVANCE, d);
      check("lead", 16'(LEAD_DEG[d[2:0]]), 16'(lead_angle_degrees));
      wr(ADDR_OVERCURRENT, 8'hFB);
      check("ocp", 16'hFFA0, {driver_standby, overcurrent_cycle_clear, overcurrent_filter_time,
         overcurrent_retry_wait, overcurrent_policy, 1'b1, overcurrent_filter_cycles});
      wr(ADDR_OVERCURRENT, 8'h20);
      check("filter2", 16'(FILTER_C2), 16'(overcurrent_filter_cycles));
      wr(ADDR_HALL, 8'h1D);
      check("hall", 16'h000F, {12'h000, position_comparator_hysteresis, brake_coasts, coast_enable,
         motor_direction});
      xfer(1'b0, ADDR_HALL, 8'h00, 16, 1'b1, r);
      xfer(1'b0, ADDR_HALL, 8'h00, 15, 1'b0, r);
      xfer(1'b0, ADDR_HALL, 8'h00, 17, 1'b0, r);
      rd(ADDR_HALL, 8'h1D);
      p = pulses;
      wr(ADDR_DRIVE, 8'h01);
      check("clear", 16'(p + 1), 16'(pulses));
      rd(ADDR_DRIVE, 8'h00);
      wr(ADDR_LOCK, {5'h1F, LOCK_CODE_SHUT});
      wr(ADDR_HALL, 8'h00);
      wr(ADDR_LOCK, 8'h05);
      rd(ADDR_HALL, 8'h1D);
      rd(ADDR_LOCK, 8'h06);
      check("lock", 16'h0001, 16'(register_lock_engaged));
      wr(ADDR_LOCK, 8'h03);
      wr(ADDR_HALL, 8'h00);
      rd(ADDR_HALL, 8'h00);
      wr(ADDR_SPEED, 8'h00);
      @(negedge sys_clk) clk_en = 1'b0;
      @(negedge sys_clk) sleep_entry = 1'b1;
      @(negedge sys_clk) sleep_entry = 1'b0;
      check("frozen", 16'h0000, 16'(speed_feedback_divider));
      @(negedge sys_clk) clk_en = 1'b1;
      @(negedge sys_clk) sleep_entry = 1'b1;
      @(negedge sys_clk) sleep_entry = 1'b0;
      xfer(1'b0, ADDR_SPEED, 8'h00, 0, 1'b0, r);
      rd(ADDR_SPEED, 8'h41);
      test_done();
   end
endmodule : motor_driver_control_regs_tb
